// ==== float_register_stack_status_tb.sv ====
`timescale 1ns/10ps
`include "fregs_params.svh"
module float_register_stack_status_tb;
    // Stimulus, observed results and bench bookkeeping.
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic op_valid = 1'b0;
    fregs_pkg::fregs_op_t op_code = fregs_pkg::FREGS_OP_NOP;
    logic [2:0] op_slot = 3'h0;
    logic [79:0] mem_data = 80'h0;
    logic [5:0] exc_mask = 6'h00;
    logic [31:0] word = 32'h0;
    logic [31:0] r = 32'hAEF3;
    logic [5:0] acc = 6'h00;
    logic ce = 1'b1;
    fregs_pkg::fregs_fmt_t fmt = fregs_pkg::FREGS_FMT_EXT;
    logic [79:0] alu_result, store_data, slot_data, e;
    logic [79:0] v[9];
    logic [5:0] exc_raise;
    logic [2:0] cmp_flags, quotient;
    logic round_up, rem_incomplete, src_out_of_range, store_valid, stack_exception;
    logic [15:0] status_word, acc_word, sw;
    logic [31:0] w;
    int error_cnt = 0;
    int checked = 0;
    fregs_top u_dut (.mclk(mclk), .rst(rst), .ce(ce), .op_valid(op_valid), .op_code(op_code),
        .op_slot(op_slot), .op_fmt(fmt), .mem_data(mem_data),
        .alu_result(alu_result), .exc_raise(exc_raise), .exc_mask(exc_mask), .round_up(round_up),
        .cmp_flags(cmp_flags), .quotient(quotient), .rem_incomplete(rem_incomplete),
        .src_out_of_range(src_out_of_range), .status_word(status_word), .acc_word(acc_word),
        .store_data(store_data), .store_valid(store_valid), .slot_data(slot_data),
        .stack_exception(stack_exception));
    fregs_core_model u_core (.word(word), .alu_result(alu_result), .exc_raise(exc_raise),
        .round_up(round_up), .cmp_flags(cmp_flags), .quotient(quotient),
        .rem_incomplete(rem_incomplete), .src_out_of_range(src_out_of_range));
    // Free-running 100 ns clock.
    initial forever #50 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////
    // Galois step of the stimulus generator.
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h00400007 : 32'h0);
    endfunction
    // Compare one observed value with its expectation.
    task automatic chk(input string n, input logic [127:0] s, input logic [127:0] x);
        checked++;
        if (s !== x) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask
    // Issue one operation; the answer is visible one cycle later, so sample just after it.
    task automatic op(input fregs_pkg::fregs_op_t c, input logic [2:0] s, input logic [79:0] d,
        input logic [31:0] x);
        @(posedge mclk);
        op_code <= c;
        op_slot <= s;
        mem_data <= d;
        word <= x;
        exc_mask <= x[21:16];
        op_valid <= 1'b1;
        @(posedge mclk);
        op_valid <= 1'b0;
        #1;
    endtask
    // Verdict and end of run.
    task automatic results();
        if (error_cnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Fill past overflow, read every slot, drain with wrap, then random flag traffic.
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        op(fregs_pkg::FREGS_OP_NOP, 3'h0, 80'h0, 32'h0);
        chk("reset", status_word, 16'h0000);
        for (int i = 0; i < 9; i++) begin
            r = lfsr(r);
            v[i] = {r[15:0], r, r};
            op(fregs_pkg::FREGS_OP_PUSH_LOAD, 3'h0, v[i], 32'h0);
            chk("top", {stack_exception, status_word[13:11]}, {i == 8, 3'(7 - i)});
        end
        sw = status_word;
        chk("fault", {sw[15], sw[9], sw[7:6], sw[0]}, 5'h1F);
        for (int s = 0; s < 8; s++) begin
            op(fregs_pkg::FREGS_OP_NOP, 3'(s), 80'h0, 32'h0);
            e = (s == 0) ? `FREGS_INDEFINITE : v[8 - s];
            chk("slot", slot_data, e);
        end
        op(fregs_pkg::FREGS_OP_STORE_SLOT, 3'h1, 80'h0, 32'h0);
        chk("store", {status_word[13:11], store_data}, {3'h7, v[7]});
        sw = status_word;
        op(fregs_pkg::FREGS_OP_STATUS_STORE, 3'h0, 80'h0, 32'h0);
        chk("acc", {acc_word, store_valid, store_data}, {sw, 1'b1, 64'h0, sw});
        op(fregs_pkg::FREGS_OP_CLEAR_EXC, 3'h0, 80'h0, 32'h0);
        chk("clear", status_word[6:0], 7'h00);
        for (int k = 0; k < 8; k++) begin
            op(fregs_pkg::FREGS_OP_POP_STORE, 3'h0, 80'h0, 32'h0);
            e = (k == 0) ? `FREGS_INDEFINITE : v[8 - k];
            chk("pop", {status_word[13:11], store_valid, store_data}, {3'(k), 1'b1, e});
        end
        op(fregs_pkg::FREGS_OP_PUSH_LOAD, 3'h0, v[1], 32'h0);
        for (int j = 0; j < 24; j++) begin
            r = lfsr(r);
            w = r & 32'h003F7FFF;
            op(fregs_pkg::FREGS_OP_ARITH, 3'h0, 80'h0, w);
            acc = acc | w[14:9];
            if (w[14]) chk("round", status_word[9], w[5]);
            w = w & 32'hFFFF81FF;
            op(fregs_pkg::FREGS_OP_PREM, 3'h0, 80'h0, w);
            chk("es", {status_word[15], status_word[7]}, {2{|(acc & ~w[21:16])}});
            chk("partial", status_word[10], w[3]);
            if (!w[3]) chk("q", {status_word[14], status_word[9:8]}, {w[1:0], w[2]});
            op(fregs_pkg::FREGS_OP_TRIG, 3'h0, 80'h0, w);
            chk("range", status_word[10], w[4]);
        end
        // Clock enable low must hold every bit of state, even with a request pending.
        sw = status_word;
        ce <= 1'b0;
        op(fregs_pkg::FREGS_OP_PUSH_LOAD, 3'h0, v[2], 32'h0);
        chk("freeze", status_word, sw);
        ce <= 1'b1;
        // Single 1.0 widens on load, then narrows to double and to integer on store.
        fmt <= fregs_pkg::FREGS_FMT_SGL;
        op(fregs_pkg::FREGS_OP_PUSH_LOAD, 3'h0, 80'h3F80_0000, 32'h0);
        op(fregs_pkg::FREGS_OP_NOP, 3'h0, 80'h0, 32'h0);
        chk("sgl load", slot_data, 80'h3FFF_8000_0000_0000_0000);
        fmt <= fregs_pkg::FREGS_FMT_DBL;
        op(fregs_pkg::FREGS_OP_STORE_SLOT, 3'h0, 80'h0, 32'h0);
        chk("dbl store", store_data, 80'h0000_3FF0_0000_0000_0000);
        fmt <= fregs_pkg::FREGS_FMT_I32;
        op(fregs_pkg::FREGS_OP_STORE_SLOT, 3'h0, 80'h0, 32'h0);
        chk("int store", store_data, 80'h1);
        fmt <= fregs_pkg::FREGS_FMT_EXT;
        // A positive normal value classifies as 010 with a clear sign flag.
        op(fregs_pkg::FREGS_OP_EXAMINE, 3'h0, 80'h0, 32'h0);
        chk("examine", {status_word[14], status_word[10:8]}, 4'h4);
        op(fregs_pkg::FREGS_OP_COMPARE, 3'h0, 80'h0, 32'h0000_0140);
        chk("compare", {status_word[14], status_word[10], status_word[8]}, 3'h5);
        sw = status_word;
        op(fregs_pkg::FREGS_OP_ENV_STORE, 3'h0, 80'h0, 32'h0);
        chk("env", {store_valid, store_data}, {1'b1, 64'h0, sw});
        op(fregs_pkg::FREGS_OP_INIT, 3'h0, 80'h0, 32'h0);
        chk("init", status_word, 16'h0000);
        // Packed data overwrites the entry and resets the top.
        r = lfsr(r);
        op(fregs_pkg::FREGS_OP_PACKED_WRITE, 3'h2, 80'h0, r);
        op(fregs_pkg::FREGS_OP_NOP, 3'h2, 80'h0, 32'h0);
        chk("packed", {status_word[13:11], slot_data}, {3'h0, 16'hFFFF, r, r});
        results();
    end
endmodule

// ==== fregs_conv.sv ====
`timescale 1ns/10ps
`include "fregs_params.svh"
module fregs_conv (
    // Load path.
    input wire logic [79:0] mem_in,
    input wire fregs_pkg::fregs_fmt_t load_fmt,
    output logic [79:0] ext_out,
    // Store path.
    input wire logic [79:0] ext_in,
    input wire fregs_pkg::fregs_fmt_t store_fmt,
    output logic [79:0] mem_out
);
    // Widening conversion; denormal inputs flush to zero to keep the path small.
    always_comb begin
        logic [31:0] mag;
        logic [16:0] exp;
        logic [5:0] msb;
        mag = 32'h0;
        exp = 17'h0;
        msb = 6'h0;
        ext_out = mem_in;
        case (load_fmt)
            fregs_pkg::FREGS_FMT_SGL: begin
                exp = 17'(mem_in[30:23]) + `FREGS_EXT_BIAS - `FREGS_SGL_BIAS;
                if (mem_in[30:23] == 8'h00) begin
                    ext_out = {mem_in[31], 79'h0};
                end else if (mem_in[30:23] == 8'hFF) begin
                    ext_out = {mem_in[31], `FREGS_EXP_MAX, 1'b1, mem_in[22:0], 40'h0};
                end else begin
                    ext_out = {mem_in[31], exp[14:0], 1'b1, mem_in[22:0], 40'h0};
                end
            end
            fregs_pkg::FREGS_FMT_DBL: begin
                exp = 17'(mem_in[62:52]) + `FREGS_EXT_BIAS - `FREGS_DBL_BIAS;
                if (mem_in[62:52] == 11'h000) begin
                    ext_out = {mem_in[63], 79'h0};
                end else if (mem_in[62:52] == 11'h7FF) begin
                    ext_out = {mem_in[63], `FREGS_EXP_MAX, 1'b1, mem_in[51:0], 11'h0};
                end else begin
                    ext_out = {mem_in[63], exp[14:0], 1'b1, mem_in[51:0], 11'h0};
                end
            end
            fregs_pkg::FREGS_FMT_I32: begin
                mag = mem_in[31] ? 32'(-mem_in[31:0]) : mem_in[31:0];
                for (int b = 0; b < 32; b++) begin
                    if (mag[b]) begin
                        msb = 6'(b);
                    end
                end
                exp = `FREGS_EXT_BIAS + 17'(msb);
                if (mag == 32'h0) begin
                    ext_out = 80'h0;
                end else begin
                    ext_out = {mem_in[31], exp[14:0], 64'({mag, 32'h0} << (6'd31 - msb))};
                end
            end
            default: ext_out = mem_in;
        endcase
    end

    // Narrowing conversion by truncation; too-large single and double values saturate to infinity.
    always_comb begin
        logic [16:0] e;
        logic [31:0] ival;
        logic [63:0] shifted;
        e = 17'(ext_in[78:64]);
        ival = 32'h0;
        shifted = 64'h0;
        mem_out = ext_in;
        case (store_fmt)
            fregs_pkg::FREGS_FMT_SGL: begin
                if (ext_in[78:64] == 15'h0 || e <= `FREGS_EXT_BIAS - `FREGS_SGL_BIAS) begin
                    mem_out = {48'h0, ext_in[79], 31'h0};
                end else if (ext_in[78:64] == `FREGS_EXP_MAX
                             || e >= `FREGS_EXT_BIAS + `FREGS_SGL_BIAS + 17'h1) begin
                    mem_out = {48'h0, ext_in[79], 8'hFF,
                               (ext_in[78:64] == `FREGS_EXP_MAX) ? ext_in[62:40] : 23'h0};
                end else begin
                    e = e - `FREGS_EXT_BIAS + `FREGS_SGL_BIAS;
                    mem_out = {48'h0, ext_in[79], e[7:0], ext_in[62:40]};
                end
            end
            fregs_pkg::FREGS_FMT_DBL: begin
                if (ext_in[78:64] == 15'h0 || e <= `FREGS_EXT_BIAS - `FREGS_DBL_BIAS) begin
                    mem_out = {16'h0, ext_in[79], 63'h0};
                end else if (ext_in[78:64] == `FREGS_EXP_MAX
                             || e >= `FREGS_EXT_BIAS + `FREGS_DBL_BIAS + 17'h1) begin
                    mem_out = {16'h0, ext_in[79], 11'h7FF,
                               (ext_in[78:64] == `FREGS_EXP_MAX) ? ext_in[62:11] : 52'h0};
                end else begin
                    e = e - `FREGS_EXT_BIAS + `FREGS_DBL_BIAS;
                    mem_out = {16'h0, ext_in[79], e[10:0], ext_in[62:11]};
                end
            end
            fregs_pkg::FREGS_FMT_I32: begin
                // Truncates toward zero; too-large magnitudes give the integer indefinite.
                if (e < `FREGS_EXT_BIAS) begin
                    ival = 32'h0;
                end else if (e > `FREGS_EXT_BIAS + 17'd30) begin
                    ival = `FREGS_INT_INDEF;
                end else begin
                    shifted = ext_in[63:0] >> (6'd63 - 6'(e - `FREGS_EXT_BIAS));
                    ival = ext_in[79] ? 32'(-shifted[31:0]) : shifted[31:0];
                end
                mem_out = {48'h0, ival};
            end
            default: mem_out = ext_in;
        endcase
    end
endmodule

// ==== fregs_core_model.sv ====
`timescale 1ns/10ps
module fregs_core_model (
    // Result word picked for the current operation.
    input wire logic [31:0] word,
    // Results handed back to the register stack.
    output logic [79:0] alu_result,
    output logic [5:0] exc_raise,
    output logic round_up,
    output logic [2:0] cmp_flags,
    output logic [2:0] quotient,
    output logic rem_incomplete,
    output logic src_out_of_range
);
    // Any flag pattern is fair, because the core never reads a flag left undefined.
    assign {exc_raise, cmp_flags, round_up, src_out_of_range, rem_incomplete, quotient} =
        word[14:0];
    assign alu_result = {word[15:0], word, word};
endmodule

// ==== fregs_params.svh ====
`ifndef FREGS_PARAMS_SVH
`define FREGS_PARAMS_SVH

// Status word field positions.
`define FREGS_SW_BUSY 15
`define FREGS_SW_C3 14
`define FREGS_SW_TOP_HI 13
`define FREGS_SW_TOP_LO 11
`define FREGS_SW_C2 10
`define FREGS_SW_C1 9
`define FREGS_SW_C0 8
`define FREGS_SW_ES 7
`define FREGS_SW_SF 6
// Exception flag positions inside the low six bits.
`define FREGS_EXC_INVALID 0
`define FREGS_EXC_INEXACT 5
// Reset values.
`define FREGS_RST_TOP 3'h0
`define FREGS_RST_EXC 6'h00
// Encoding constants of the extended, single, double and integer formats.
`define FREGS_EXT_BIAS 17'h03FFF
`define FREGS_SGL_BIAS 17'h0007F
`define FREGS_DBL_BIAS 17'h003FF
`define FREGS_EXP_MAX 15'h7FFF
`define FREGS_INDEFINITE 80'hFFFF_C000_0000_0000_0000
`define FREGS_PACKED_EXP 16'hFFFF
`define FREGS_INT_INDEF 32'h8000_0000
`endif

// ==== fregs_pkg.sv ====
package fregs_pkg;
    // Operations issued by the execution core.
    typedef enum logic [3:0] {
        FREGS_OP_NOP = 4'h0,
        FREGS_OP_PUSH_LOAD = 4'h1,
        FREGS_OP_LOAD_SLOT = 4'h2,
        FREGS_OP_POP_STORE = 4'h3,
        FREGS_OP_STORE_SLOT = 4'h4,
        FREGS_OP_EXCHANGE = 4'h5,
        FREGS_OP_ARITH = 4'h6,
        FREGS_OP_COMPARE = 4'h7,
        FREGS_OP_EXAMINE = 4'h8,
        FREGS_OP_PREM = 4'h9,
        FREGS_OP_TRIG = 4'hA,
        FREGS_OP_STATUS_STORE = 4'hB,
        FREGS_OP_ENV_STORE = 4'hC,
        FREGS_OP_CLEAR_EXC = 4'hD,
        FREGS_OP_INIT = 4'hE,
        FREGS_OP_PACKED_WRITE = 4'hF
    } fregs_op_t;

    // Memory formats for loads and stores.
    typedef enum logic [1:0] {
        FREGS_FMT_EXT = 2'h0,
        FREGS_FMT_SGL = 2'h1,
        FREGS_FMT_DBL = 2'h2,
        FREGS_FMT_I32 = 2'h3
    } fregs_fmt_t;

    // Complete state of the register stack.
    typedef struct packed {
        logic [7:0][79:0] entry;
        logic [7:0] tag_valid;
        logic [2:0] top;
        logic c3;
        logic c2;
        logic c1;
        logic c0;
        logic es;
        logic sf;
        logic [5:0] exc;
        logic [15:0] acc;
        logic [79:0] store_data;
        logic store_valid;
        logic [79:0] slot_data;
        logic stack_exc;
    } fregs_state_t;
endpackage

// ==== fregs_top.sv ====
`timescale 1ns/10ps
`include "fregs_params.svh"
module fregs_top #(
    parameter int ENTRIES = 8,
    parameter int ENTRY_WIDTH = 80
) (
    // Clock, reset and clock enable.
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Operation request from the execution core.
    input wire logic op_valid,
    input wire fregs_pkg::fregs_op_t op_code,
    input wire logic [2:0] op_slot,
    input wire fregs_pkg::fregs_fmt_t op_fmt,
    input wire logic [79:0] mem_data,
    // Results computed by the core's arithmetic units.
    input wire logic [79:0] alu_result,
    input wire logic [5:0] exc_raise,
    input wire logic [5:0] exc_mask,
    input wire logic round_up,
    input wire logic [2:0] cmp_flags,
    input wire logic [2:0] quotient,
    input wire logic rem_incomplete,
    input wire logic src_out_of_range,
    // Results returned to the core.
    output logic [15:0] status_word,
    output logic [15:0] acc_word,
    output logic [79:0] store_data,
    output logic store_valid,
    output logic [79:0] slot_data,
    output logic stack_exception
);
    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks: the pointer arithmetic is fixed at eight 80-bit entries.
    if (ENTRIES != 8 || ENTRY_WIDTH != 80) begin : g_bad_geometry
        $error("fregs_top supports only eight 80-bit entries");
    end

    fregs_pkg::fregs_state_t cur;
    fregs_pkg::fregs_state_t next_cur;
    logic [2:0] phys_slot;
    logic [2:0] push_top;
    logic [2:0] pop_top;
    logic [79:0] load_ext;
    logic [79:0] store_mem;
    logic [79:0] slot_value;
    logic [7:0] sel_slot;

    ////////////////////////////////////////////////////////////////////////////////
    // Stack-relative addressing; the 3-bit sums wrap modulo eight by construction.
    assign phys_slot = 3'(cur.top + op_slot);
    assign push_top = 3'(cur.top - 3'h1);
    assign pop_top = 3'(cur.top + 3'h1);

    // One-hot selection of the physical entry named by the operand slot.
    for (genvar g = 0; g < ENTRIES; g++) begin : g_sel
        assign sel_slot[g] = (phys_slot == 3'(g));
    end

    // Read mux driven by the one-hot select.
    always_comb begin
        slot_value = 80'h0;
        for (int k = 0; k < ENTRIES; k++) begin
            if (sel_slot[k]) begin
                slot_value = cur.entry[k];
            end
        end
    end

    // Format converters shared by the push, slot load, pop and slot store operations.
    fregs_conv u_conv (
        .mem_in(mem_data),
        .load_fmt(op_fmt),
        .ext_out(load_ext),
        .ext_in(slot_value),
        .store_fmt(op_fmt),
        .mem_out(store_mem)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic. Entries are touched only by write operations, so nothing the
    // core does around calls and returns disturbs them.
    always_comb begin
        logic src_empty;
        next_cur = cur;
        next_cur.store_valid = 1'b0;
        next_cur.stack_exc = 1'b0;
        next_cur.slot_data = slot_value;
        src_empty = !cur.tag_valid[phys_slot];
        if (op_valid) begin
            case (op_code)
                fregs_pkg::FREGS_OP_PUSH_LOAD: begin
                    next_cur.top = push_top;
                    next_cur.c1 = 1'b0;
                    if (cur.tag_valid[push_top]) begin
                        // Overflow: keep an indefinite rather than the new value.
                        next_cur.entry[push_top] = `FREGS_INDEFINITE;
                        next_cur.exc[`FREGS_EXC_INVALID] = 1'b1;
                        next_cur.sf = 1'b1;
                        next_cur.c1 = 1'b1;
                        next_cur.stack_exc = 1'b1;
                    end else begin
                        next_cur.entry[push_top] = load_ext;
                    end
                    next_cur.tag_valid[push_top] = 1'b1;
                end
                fregs_pkg::FREGS_OP_LOAD_SLOT: begin
                    next_cur.entry[phys_slot] = load_ext;
                    next_cur.tag_valid[phys_slot] = 1'b1;
                    next_cur.c1 = 1'b0;
                end
                fregs_pkg::FREGS_OP_POP_STORE, fregs_pkg::FREGS_OP_STORE_SLOT: begin
                    next_cur.store_data = store_mem;
                    next_cur.store_valid = 1'b1;
                    next_cur.c1 = 1'b0;
                    if (src_empty) begin
                        next_cur.exc[`FREGS_EXC_INVALID] = 1'b1;
                        next_cur.sf = 1'b1;
                        next_cur.stack_exc = 1'b1;
                    end
                    if (op_code == fregs_pkg::FREGS_OP_POP_STORE) begin
                        next_cur.tag_valid[cur.top] = 1'b0;
                        next_cur.top = pop_top;
                    end
                end
                fregs_pkg::FREGS_OP_EXCHANGE: begin
                    next_cur.entry[cur.top] = slot_value;
                    next_cur.entry[phys_slot] = cur.entry[cur.top];
                    next_cur.tag_valid[cur.top] = cur.tag_valid[phys_slot];
                    next_cur.tag_valid[phys_slot] = cur.tag_valid[cur.top];
                    next_cur.c1 = 1'b0;
                end
                fregs_pkg::FREGS_OP_ARITH, fregs_pkg::FREGS_OP_TRIG: begin
                    next_cur.entry[phys_slot] = alu_result;
                    next_cur.tag_valid[phys_slot] = 1'b1;
                    next_cur.exc = cur.exc | exc_raise;
                    next_cur.c1 = exc_raise[`FREGS_EXC_INEXACT] & round_up;
                    if (op_code == fregs_pkg::FREGS_OP_TRIG) begin
                        next_cur.c2 = src_out_of_range;
                    end
                end
                fregs_pkg::FREGS_OP_COMPARE: begin
                    next_cur.exc = cur.exc | exc_raise;
                    next_cur.c3 = cmp_flags[2];
                    next_cur.c2 = cmp_flags[1];
                    next_cur.c0 = cmp_flags[0];
                    next_cur.c1 = 1'b0;
                end
                fregs_pkg::FREGS_OP_EXAMINE: begin
                    next_cur.c1 = slot_value[79];
                    if (src_empty) begin
                        {next_cur.c3, next_cur.c2, next_cur.c0} = 3'h5;
                    end else if (slot_value[78:64] == 15'h0) begin
                        {next_cur.c3, next_cur.c2, next_cur.c0} = 3'h4;
                    end else if (slot_value[78:64] == `FREGS_EXP_MAX) begin
                        {next_cur.c3, next_cur.c2, next_cur.c0} =
                            (slot_value[62:0] == 63'h0) ? 3'h3 : 3'h1;
                    end else begin
                        {next_cur.c3, next_cur.c2, next_cur.c0} = 3'h2;
                    end
                end
                fregs_pkg::FREGS_OP_PREM: begin
                    next_cur.entry[cur.top] = alu_result;
                    next_cur.exc = cur.exc | exc_raise;
                    next_cur.c2 = rem_incomplete;
                    if (!rem_incomplete) begin
                        next_cur.c0 = quotient[2];
                        next_cur.c3 = quotient[1];
                        next_cur.c1 = quotient[0];
                    end
                end
                fregs_pkg::FREGS_OP_STATUS_STORE: begin
                    next_cur.acc = status_word;
                    next_cur.store_data = {64'h0, status_word};
                    next_cur.store_valid = 1'b1;
                end
                fregs_pkg::FREGS_OP_ENV_STORE: begin
                    next_cur.store_data = {64'h0, status_word};
                    next_cur.store_valid = 1'b1;
                end
                fregs_pkg::FREGS_OP_CLEAR_EXC: begin
                    next_cur.exc = `FREGS_RST_EXC;
                    next_cur.sf = 1'b0;
                end
                fregs_pkg::FREGS_OP_INIT: begin
                    next_cur.exc = `FREGS_RST_EXC;
                    next_cur.sf = 1'b0;
                    next_cur.top = `FREGS_RST_TOP;
                    next_cur.tag_valid = 8'h00;
                    {next_cur.c3, next_cur.c2, next_cur.c1, next_cur.c0} = 4'h0;
                end
                fregs_pkg::FREGS_OP_PACKED_WRITE: begin
                    // Packed data lands in the mantissa field, clobbering any float.
                    next_cur.entry[phys_slot] = {`FREGS_PACKED_EXP, alu_result[63:0]};
                    next_cur.top = `FREGS_RST_TOP;
                    next_cur.tag_valid = 8'hFF;
                end
                default: next_cur.c1 = cur.c1;
            endcase
        end
        // A newly raised fault on a source read also marks the invalid flag.
        if (next_cur.stack_exc) begin
            next_cur.exc[`FREGS_EXC_INVALID] = 1'b1;
        end
        next_cur.es = |(next_cur.exc & ~exc_mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register; reset clears it even with clock enable low, which otherwise freezes everything.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cur <= '0;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    // Status word fields; bit 15 repeats the summary flag for older software.
    assign status_word = {cur.es, cur.c3, cur.top, cur.c2, cur.c1, cur.c0,
                          cur.es, cur.sf, cur.exc};
    assign acc_word = cur.acc;
    assign store_data = cur.store_data;
    assign store_valid = cur.store_valid;
    assign slot_data = cur.slot_data;
    assign stack_exception = cur.stack_exc;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the stack pointer, flags and outputs.
    logic take;
    assign take = ce && op_valid;

    chk_push_decrement: assert property (@(posedge mclk) disable iff (rst)
        take && op_code == fregs_pkg::FREGS_OP_PUSH_LOAD
        |=> status_word[13:11] == 3'($past(status_word[13:11]) - 3'h1))
        else $error("push did not decrement top");

    chk_push_wrap: assert property (@(posedge mclk) disable iff (rst)
        take && op_code == fregs_pkg::FREGS_OP_PUSH_LOAD && status_word[13:11] == 3'h0
        |=> status_word[13:11] == 3'h7)
        else $error("push at top 0 did not wrap to 7");

    chk_pop_wrap: assert property (@(posedge mclk) disable iff (rst)
        take && op_code == fregs_pkg::FREGS_OP_POP_STORE && status_word[13:11] == 3'h7
        |=> status_word[13:11] == 3'h0 && store_valid)
        else $error("pop at top 7 did not wrap to 0");

    chk_pop_data: assert property (@(posedge mclk) disable iff (rst)
        take && op_code == fregs_pkg::FREGS_OP_POP_STORE && op_fmt == fregs_pkg::FREGS_FMT_EXT
        && op_slot == 3'h0 |=> store_data == $past(slot_value))
        else $error("pop did not output the old top entry");

    chk_overflow_flag: assert property (@(posedge mclk) disable iff (rst)
        take && op_code == fregs_pkg::FREGS_OP_PUSH_LOAD && cur.tag_valid[push_top]
        |=> stack_exception && status_word[6] && status_word[9] && status_word[0])
        else $error("overflow not flagged");

    chk_summary_mirror: assert property (@(posedge mclk) disable iff (rst)
        status_word[15] == status_word[7])
        else $error("bit 15 differs from summary flag");

    chk_fault_sticky: assert property (@(posedge mclk) disable iff (rst)
        status_word[6] && !(take && (op_code == fregs_pkg::FREGS_OP_CLEAR_EXC
        || op_code == fregs_pkg::FREGS_OP_INIT)) |=> status_word[6])
        else $error("stack fault flag cleared on its own");

    chk_rem_quotient: assert property (@(posedge mclk) disable iff (rst)
        take && op_code == fregs_pkg::FREGS_OP_PREM && !rem_incomplete
        |=> {status_word[8], status_word[14], status_word[9], status_word[10]}
            == {$past(quotient), 1'b0})
        else $error("quotient bits misplaced");

    chk_trig_range: assert property (@(posedge mclk) disable iff (rst)
        take && op_code == fregs_pkg::FREGS_OP_TRIG
        |=> status_word[10] == $past(src_out_of_range))
        else $error("range flag wrong after trig");

    chk_acc_copy: assert property (@(posedge mclk) disable iff (rst)
        take && op_code == fregs_pkg::FREGS_OP_STATUS_STORE |=> acc_word == $past(status_word))
        else $error("accumulator did not receive status word");
endmodule
